//--- rxp_port.sv
// Transceiver-side MII/RMII receive port with configuration strap capture
`timescale 1ns/1ps
`include "rxp_map.svh"

module rxp_port (
	// Clock, reset and enable
	input  wire logic       CLK,
	input  wire logic       RST_B,
	input  wire logic       CE,
	input  wire logic       SYS_RESET,
	// Decoded receive stream from the core
	input  wire logic       CORE_VALID,
	output logic            CORE_READY,
	input  wire logic [4:0] CORE_SYMBOL,
	input  wire logic       CORE_ERR,
	input  wire logic       CORE_LAST,
	// Line status from the core
	input  wire logic       CORE_CARRIER,
	input  wire logic       CORE_COLLISION,
	input  wire logic       CORE_LPI,
	input  wire logic       TX_ACTIVE,
	// Operating configuration
	input  wire logic       SPEED_100,
	input  wire logic       FULL_DUPLEX,
	input  wire logic       EEE_EN,
	input  wire logic       SYMBOL_MODE,
	// Reduced interface reference clock
	input  wire logic       REF_CLK,
	// Receive pins toward the controller
	output logic [3:0]      RXD,
	output logic            RXER_RXD4,
	output logic            RXDV,
	output logic            RXCLK,
	output logic            CRS,
	output logic            COL_CRSDV,
	output logic            PIN_OE,
	// Configuration strap pins
	input  wire logic       MGMT_ADDR_STRAP_BIT0,
	input  wire logic       MGMT_ADDR_STRAP_BIT1,
	input  wire logic       MGMT_ADDR_STRAP_BIT2,
	input  wire logic       DEFAULT_OP_STRAP_BIT0,
	input  wire logic       DEFAULT_OP_STRAP_BIT1,
	input  wire logic       DEFAULT_OP_STRAP_BIT2,
	input  wire logic       REDUCED_IFACE_SELECT_STRAP,
	// Latched configuration
	output logic [2:0]      MGMT_ADDR,
	output logic [2:0]      DEFAULT_MODE,
	output logic            RMII_MODE,
	// Management address check
	input  wire logic [2:0] SMI_ADDR,
	output logic            SMI_ADDR_HIT
);

	// Picks one dibit of a nibble, low half first on the wire
	function automatic logic [1:0] rxp_dibit(input logic [3:0] nib, input logic hi);
		rxp_dibit = hi ? nib[3:2] : nib[1:0];
	endfunction

	rxp_stream_if in_if ();
	rxp_stream_if out_if ();

	logic [6:0]           strap_raw;
	logic [6:0]           strap_s;
	logic                 ref_s;
	logic                 ref_d;
	logic [1:0]           strap_hold;
	logic                 pin_oe;
	logic [`RXP_DIV_W-1:0] div_cnt;
	logic                 rxclk_q;
	rxp_pkg::rxp_state_e  state;
	rxp_pkg::rxp_state_e  next_state;
	logic [3:0]           cur_nib;
	logic                 cur_gate;
	logic                 cur_err;
	logic [3:0]           prev_nib;
	logic                 sfd_seen;

	// Strap pins and reference clock come from outside the clock domain
	assign strap_raw = {REDUCED_IFACE_SELECT_STRAP,
		DEFAULT_OP_STRAP_BIT2, DEFAULT_OP_STRAP_BIT1, DEFAULT_OP_STRAP_BIT0,
		MGMT_ADDR_STRAP_BIT2, MGMT_ADDR_STRAP_BIT1, MGMT_ADDR_STRAP_BIT0};

	rxp_sync #(
		.W (7)
	) u_strap_sync (
		.clk   (CLK),
		.rst_b (1'b1),
		.ce    (CE),
		.d     (strap_raw),
		.q     (strap_s)
	);

	rxp_sync #(
		.W (1)
	) u_ref_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.ce    (CE),
		.d     (REF_CLK),
		.q     (ref_s)
	);

	// Receive buffer between the core and the pin sequencer
	rxp_fifo #(
		.W (`RXP_WORD_W),
		.D (`RXP_FIFO_DEPTH)
	) u_fifo (
		.clk   (CLK),
		.rst_b (RST_B),
		.ce    (CE),
		.wr    (in_if),
		.rd    (out_if)
	);

	// Core stream into the buffer
	assign in_if.valid     = CORE_VALID;
	assign in_if.data.last = CORE_LAST;
	assign in_if.data.err  = CORE_ERR;
	assign in_if.data.sym  = CORE_SYMBOL;
	assign CORE_READY      = in_if.ready;

	// Strap window covers reset plus synchroniser latency
	wire any_reset    = ~RST_B | SYS_RESET;
	wire strap_window = any_reset | (strap_hold != `RXP_STRAP_DONE);

	// Strap window counter and pin drive enable
	always_ff @(posedge CLK) begin
		if (any_reset) begin
			strap_hold <= `RXP_STRAP_HOLD;
			pin_oe     <= 1'b0;
		end else if (CE) begin
			if (strap_hold != `RXP_STRAP_DONE) begin
				strap_hold <= strap_hold - `RXP_STRAP_STEP;
			end
			pin_oe <= (strap_hold == `RXP_STRAP_DONE);
		end
	end

	// Latch straps only inside the window, hold them afterwards
	always_ff @(posedge CLK) begin
		if (CE && strap_window) begin
			MGMT_ADDR    <= strap_s[2:0];
			DEFAULT_MODE <= strap_s[5:3];
			RMII_MODE    <= strap_s[6];
		end
	end

	// Management address compare against the latched address
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			SMI_ADDR_HIT <= 1'b0;
		end else if (CE) begin
			SMI_ADDR_HIT <= pin_oe & (SMI_ADDR == MGMT_ADDR);
		end
	end

	// Receive clock divider, half period chosen by speed
	wire [`RXP_DIV_W-1:0] half = SPEED_100 ? `RXP_FAST_HALF : `RXP_SLOW_HALF;
	wire div_wrap = (div_cnt >= half - `RXP_DIV_ONE);
	wire mii_fall = ~RMII_MODE & div_wrap & rxclk_q;
	wire ref_rise = RMII_MODE & ref_s & ~ref_d;
	wire tick     = pin_oe & (mii_fall | ref_rise);

	// Divider and reference edge history
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			div_cnt <= `RXP_DIV_ZERO;
			rxclk_q <= 1'b0;
			ref_d   <= 1'b0;
		end else if (CE) begin
			ref_d <= ref_s;
			if (RMII_MODE || !pin_oe) begin
				div_cnt <= `RXP_DIV_ZERO;
				rxclk_q <= 1'b0;
			end else if (div_wrap) begin
				div_cnt <= `RXP_DIV_ZERO;
				rxclk_q <= ~rxclk_q;
			end else begin
				div_cnt <= div_cnt + `RXP_DIV_ONE;
			end
		end
	end
	assign RXCLK = rxclk_q;

	// Drain decode
	rxp_pkg::rxp_word_s head;
	assign head = out_if.data;
	wire have       = out_if.valid;
	wire take       = tick & have & (state != rxp_pkg::RXP_HI);
	wire ten_rmii   = RMII_MODE & ~SPEED_100;
	wire echo_block = ten_rmii & ~FULL_DUPLEX & TX_ACTIVE;
	wire sfd_hit    = take & ten_rmii & (prev_nib == `RXP_NIB_PRE)
		& (head.sym[3:0] == `RXP_NIB_SFD);
	wire gate_now   = echo_block | (ten_rmii & ~(sfd_seen | sfd_hit));
	wire frame_end  = take & head.last;
	assign out_if.ready = take;

	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			rxp_pkg::RXP_IDLE: begin
				if (take) begin
					next_state = RMII_MODE ? rxp_pkg::RXP_HI : rxp_pkg::RXP_STREAM;
				end
			end
			rxp_pkg::RXP_STREAM: begin
				if (take) begin
					next_state = RMII_MODE ? rxp_pkg::RXP_HI : rxp_pkg::RXP_STREAM;
				end else if (tick) begin
					next_state = rxp_pkg::RXP_IDLE;
				end
			end
			rxp_pkg::RXP_HI: begin
				if (tick) begin
					next_state = rxp_pkg::RXP_STREAM;
				end
			end
			default: begin
				next_state = rxp_pkg::RXP_IDLE;
			end
		endcase
	end

	// Sequencer state and frame tracking
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			state    <= rxp_pkg::RXP_IDLE;
			prev_nib <= `RXP_NIB_ZERO;
			sfd_seen <= 1'b0;
			cur_nib  <= `RXP_NIB_ZERO;
			cur_gate <= 1'b0;
			cur_err  <= 1'b0;
		end else if (CE) begin
			state <= next_state;
			if (take) begin
				cur_nib  <= head.sym[3:0];
				cur_gate <= gate_now;
				cur_err  <= head.err;
			end
			if (frame_end) begin
				prev_nib <= `RXP_NIB_ZERO;
				sfd_seen <= 1'b0;
			end else if (take) begin
				prev_nib <= head.sym[3:0];
				sfd_seen <= sfd_seen | sfd_hit;
			end
		end
	end

	// Per-mode pin values, presented on the next tick
	wire [3:0] mii_rxd   = take ? head.sym[3:0] : `RXP_NIB_ZERO;
	wire       mii_err   = take ? head.err : (EEE_EN & CORE_LPI);
	wire       mii_er4   = SYMBOL_MODE ? (take & head.sym[4]) : mii_err;
	wire [1:0] lo_dibit  = gate_now ? 2'h0 : rxp_dibit(head.sym[3:0], 1'b0);
	wire [1:0] hi_dibit  = cur_gate ? 2'h0 : rxp_dibit(cur_nib, 1'b1);
	wire       in_hi     = (state == rxp_pkg::RXP_HI);
	wire [1:0] rmii_rxd  = take ? lo_dibit : (in_hi ? hi_dibit : 2'h0);
	wire       rmii_err  = ~echo_block & (take ? head.err : (in_hi & cur_err));
	wire       rmii_crs  = ~echo_block & (CORE_CARRIER | take | in_hi);

	// Pin registers; MII updates land on the falling receive clock edge
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			RXD       <= `RXP_NIB_ZERO;
			RXER_RXD4 <= 1'b0;
			RXDV      <= 1'b0;
			CRS       <= 1'b0;
			COL_CRSDV <= 1'b0;
		end else if (CE) begin
			if (!pin_oe) begin
				RXD       <= `RXP_NIB_ZERO;
				RXER_RXD4 <= 1'b0;
				RXDV      <= 1'b0;
				CRS       <= 1'b0;
				COL_CRSDV <= 1'b0;
			end else if (tick && RMII_MODE) begin
				RXD       <= {2'h0, rmii_rxd};
				RXER_RXD4 <= rmii_err;
				RXDV      <= 1'b0;
				CRS       <= 1'b0;
				COL_CRSDV <= rmii_crs;
			end else if (tick) begin
				RXD       <= mii_rxd;
				RXER_RXD4 <= mii_er4;
				RXDV      <= take;
				CRS       <= CORE_CARRIER;
				COL_CRSDV <= CORE_COLLISION;
			end
		end
	end

	// Pins are driven once the strap window has closed
	assign PIN_OE = pin_oe;

endmodule // rxp_port

//--- rxp_map.svh
// Named offsets, field positions and timing counts for the receive port
`ifndef RXP_MAP_SVH
`define RXP_MAP_SVH

// Core clock and receive clock rates in kHz
`define RXP_CLK_KHZ        250000
`define RXP_FAST_KHZ       25000
`define RXP_SLOW_KHZ       2500
`define RXP_DIV_W          6
// Core cycles per receive clock half period
`define RXP_FAST_HALF      (6'(`RXP_CLK_KHZ / (2 * `RXP_FAST_KHZ)))
`define RXP_SLOW_HALF      (6'(`RXP_CLK_KHZ / (2 * `RXP_SLOW_KHZ)))
`define RXP_DIV_ONE        6'h01
`define RXP_DIV_ZERO       6'h00

// Preamble and start-of-frame nibbles, in arrival order
`define RXP_NIB_PRE        4'h5
`define RXP_NIB_SFD        4'hD
`define RXP_NIB_ZERO       4'h0

// Cycles the strap capture window outlasts reset
`define RXP_STRAP_HOLD     2'h3
`define RXP_STRAP_DONE     2'h0
`define RXP_STRAP_STEP     2'h1

// Buffer shape
`define RXP_FIFO_DEPTH     8
`define RXP_WORD_W         7

`endif

//--- rxp_pkg.sv
// Types shared by the receive port modules
package rxp_pkg;

	// One buffered receive code-group
	typedef struct packed {
		logic       last;
		logic       err;
		logic [4:0] sym;
	} rxp_word_s;

	// Drain sequencer states
	typedef enum logic [1:0] {
		RXP_IDLE,
		RXP_STREAM,
		RXP_HI
	} rxp_state_e;

endpackage

//--- rxp_stream_if.sv
// Valid/ready word stream between the receive port modules
`timescale 1ns/1ps

interface rxp_stream_if;
	logic              valid;
	logic              ready;
	rxp_pkg::rxp_word_s data;

	// Producer side
	modport src (output valid, output data, input ready);
	// Consumer side
	modport snk (input valid, input data, output ready);
endinterface

//--- rxp_sync.sv
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps

module rxp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta <= '0;
			q    <= '0;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // rxp_sync

//--- rxp_fifo.sv
// Word FIFO with registered read stage and registered room flag
`timescale 1ns/1ps
`include "rxp_map.svh"

module rxp_fifo #(
	parameter int W = `RXP_WORD_W,
	parameter int D = `RXP_FIFO_DEPTH
) (
	input  wire logic   clk,
	input  wire logic   rst_b,
	input  wire logic   ce,
	rxp_stream_if.snk   wr,
	rxp_stream_if.src   rd
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0]   cnt;
	logic [AW:0]   next_cnt;
	logic          room;
	logic          out_valid;
	logic [W-1:0]  out_data;
	logic          push;
	logic          load;

	// Handshake decode
	assign push     = wr.valid & room;
	assign load     = (cnt != '0) & (~out_valid | rd.ready);
	assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(load);
	assign wr.ready = room;
	assign rd.valid = out_valid;
	assign rd.data  = out_data;

	// Storage array, no reset needed
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wptr] <= wr.data;
		end
	end

	// Pointers, count and registered read word
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wptr      <= '0;
			rptr      <= '0;
			cnt       <= '0;
			room      <= 1'b0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (ce) begin
			cnt  <= next_cnt;
			room <= (next_cnt != (AW+1)'(D));
			if (push) begin
				wptr <= wptr + 1'b1;
			end
			if (load) begin
				rptr      <= rptr + 1'b1;
				out_data  <= mem[rptr];
				out_valid <= 1'b1;
			end else if (rd.ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule // rxp_fifo

//--- rxp_port_chk.sv
// Port assertions for the receive port, bound to its top module
`timescale 1ns/1ps

module rxp_port_chk (
	// Clock, reset and configuration
	input wire logic       CLK,
	input wire logic       RST_B,
	input wire logic       SYS_RESET,
	input wire logic       SPEED_100,
	input wire logic       FULL_DUPLEX,
	input wire logic       EEE_EN,
	input wire logic       SYMBOL_MODE,
	input wire logic       TX_ACTIVE,
	// Receive pins
	input wire logic [3:0] RXD,
	input wire logic       RXER_RXD4,
	input wire logic       RXDV,
	input wire logic       RXCLK,
	input wire logic       CRS,
	input wire logic       COL_CRSDV,
	input wire logic       PIN_OE,
	// Straps and address match
	input wire logic [2:0] MGMT_ADDR,
	input wire logic [2:0] DEFAULT_MODE,
	input wire logic       RMII_MODE,
	input wire logic [2:0] SMI_ADDR,
	input wire logic       SMI_ADDR_HIT
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	// Pin behaviour per interface mode
	a_rmii_pins_quiet: assert property (PIN_OE && RMII_MODE |-> !RXDV && !CRS && !RXCLK && RXD[3:2] == 2'h0)
		else $error("wide pins active in reduced mode");
	a_mii_edge_sync: assert property (PIN_OE && $past(PIN_OE) && !RMII_MODE
		&& ($changed(RXD) || $changed(RXDV) || $changed(CRS)) |-> $fell(RXCLK))
		else $error("wide outputs moved off the clock fall");
	a_rxclk_fast: assert property (PIN_OE && !RMII_MODE && SPEED_100 && $rose(RXCLK) |-> RXCLK [*5] ##1 !RXCLK)
		else $error("fast receive clock high phase wrong");
	a_lpi_needs_eee: assert property (PIN_OE && !RMII_MODE && !SYMBOL_MODE && !RXDV && RXER_RXD4 |-> EEE_EN)
		else $error("idle indication without low power enabled");
	a_no_echo: assert property (PIN_OE && RMII_MODE && !SPEED_100 && !FULL_DUPLEX && TX_ACTIVE && $past(TX_ACTIVE, 40)
		|-> RXD[1:0] == 2'h0 && !COL_CRSDV)
		else $error("own transmit echoed on receive");
	// Strap capture and address match
	a_addr_hit: assert property ($past(RST_B) |-> SMI_ADDR_HIT == ($past(SMI_ADDR) == $past(MGMT_ADDR) && $past(PIN_OE)))
		else $error("address match wrong");
	a_strap_hold: assert property (PIN_OE && $past(PIN_OE) && !$past(SYS_RESET)
		|-> $stable(MGMT_ADDR) && $stable(DEFAULT_MODE) && $stable(RMII_MODE))
		else $error("latched straps moved");
	a_window_after_reset: assert property (RST_B && !$past(RST_B) |-> !PIN_OE ##1 !PIN_OE ##1 !PIN_OE)
		else $error("pins driven inside strap window");
endmodule // rxp_port_chk

bind rxp_port rxp_port_chk rxp_port_chk_inst (.*);

//--- rxp_mac_model.sv
// Receiving controller model that samples the receive pins
`timescale 1ns/1ps

module rxp_mac_model (
	// Pin clocks and mode
	input wire logic        rxclk,
	input wire logic        ref_clk,
	input wire logic        rmii,
	// Receive pins
	input wire logic [3:0]  rxd,
	input wire logic        rxer,
	input wire logic        rxdv,
	input wire logic        crs_dv,
	// Captured history and unit count
	output logic     [39:0] sh,
	output int              cnt
);
	// Empty history at start
	initial begin
		sh = 40'h0;
		cnt = 0;
	end
	// Wide mode: code-group with its error or symbol bit, error read only with valid
	always @(posedge rxclk) begin
		if (!rmii && rxdv) begin
			sh <= {sh[34:0], rxer, rxd};
			cnt <= cnt + 1;
		end
	end
	// Reduced mode: error line left unused, one dibit per reference edge
	always @(posedge ref_clk) begin
		if (rmii && crs_dv) begin
			sh <= {sh[37:0], rxd[1:0]};
			cnt <= cnt + 1;
		end
	end
endmodule // rxp_mac_model

//--- tb_top.sv
// Self-checking bench for the transceiver receive port
`timescale 1ns/1ps

module tb_top;
	logic        CLK, RST_B, CE, SYS_RESET, CORE_VALID, CORE_READY, CORE_ERR, CORE_LAST, CORE_CARRIER;
	logic        CORE_COLLISION, CORE_LPI, TX_ACTIVE, REF_CLK, SPEED_100, FULL_DUPLEX, EEE_EN, SYMBOL_MODE;
	logic        RXER_RXD4, RXDV, RXCLK, CRS, COL_CRSDV, PIN_OE, RMII_MODE, SMI_ADDR_HIT, refused;
	logic [4:0]  CORE_SYMBOL;
	logic [3:0]  RXD;
	logic [2:0]  MGMT_ADDR, DEFAULT_MODE, SMI_ADDR;
	logic [6:0]  straps;
	logic [39:0] sh, e;
	wire         MGMT_ADDR_STRAP_BIT0, MGMT_ADDR_STRAP_BIT1, MGMT_ADDR_STRAP_BIT2, REDUCED_IFACE_SELECT_STRAP;
	wire         DEFAULT_OP_STRAP_BIT0, DEFAULT_OP_STRAP_BIT1, DEFAULT_OP_STRAP_BIT2;
	int          cnt, base, n_errors, num_checks;

	// Strap pins: interface, mode[2:0], address[2:0]
	assign {REDUCED_IFACE_SELECT_STRAP, DEFAULT_OP_STRAP_BIT2, DEFAULT_OP_STRAP_BIT1, DEFAULT_OP_STRAP_BIT0,
		MGMT_ADDR_STRAP_BIT2, MGMT_ADDR_STRAP_BIT1, MGMT_ADDR_STRAP_BIT0} = straps;

	rxp_port rxp_port_inst (.*);
	rxp_mac_model rxp_mac_model_inst (.rxclk(RXCLK), .ref_clk(REF_CLK), .rmii(RMII_MODE), .rxd(RXD),
		.rxer(RXER_RXD4), .rxdv(RXDV), .crs_dv(COL_CRSDV), .sh(sh), .cnt(cnt));

	// Core clock, 4 ns
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// Reference clock, 125 ns, phase unrelated to the core clock
	initial begin
		REF_CLK = 1'b0;
		#1.3;
		forever #62.5 REF_CLK = ~REF_CLK;
	end

	task chk(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp)
			n_errors++;
		if (got !== exp)
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Offer one code-group and hold it until the edge that takes it
	task push(input logic [4:0] s, input logic l);
		{CORE_SYMBOL, CORE_ERR, CORE_LAST, CORE_VALID} = {s, s[4], l, 1'b1};
		for (int i = 0; i < 3000 && !CORE_READY; i++) begin
			refused = 1'b1;
			@(negedge CLK);
		end
		@(negedge CLK);
	endtask

	// Four-word frame, then wait for k units at the controller
	task send(input logic [19:0] w, input int k);
		base = cnt;
		for (int i = 3; i >= 0; i--)
			push(w[i*5 +: 5], i == 0);
		CORE_VALID = 1'b0;
		for (int i = 0; i < 3000 && cnt < base + k; i++) @(negedge CLK);
		if (cnt < base + k)
			n_errors++;
	endtask

	task restart(input logic [6:0] s, input logic spd);
		{straps, SPEED_100, RST_B} = {s, spd, 1'b0};
		repeat (3) @(negedge CLK);
		RST_B = 1'b1;
		for (int i = 0; i < 50 && !PIN_OE; i++) @(negedge CLK);
		// Address match register follows the drive enable by one cycle
		@(negedge CLK);
	endtask

	// Expected dibit stream, low dibit first, first z nibbles held low
	function automatic logic [15:0] dib(input logic [19:0] w, input int z);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 3; i >= 0; i--)
			r = {r[11:0], (3 - i < z) ? 4'h0 : {w[i*5 +: 2], w[i*5+2 +: 2]}};
		return r;
	endfunction

	// Watchdog
	initial begin
		#300000;
		n_errors++;
		$display("watchdog expired");
		end_of_test;
	end

	initial begin
		{SYS_RESET, CORE_VALID, CORE_SYMBOL, CORE_ERR, CORE_LAST, CORE_CARRIER, CORE_COLLISION, TX_ACTIVE} = '0;
		{CE, CORE_LPI, FULL_DUPLEX, EEE_EN, SYMBOL_MODE, SMI_ADDR, refused} = 9'h1EA;
		n_errors = 0;
		num_checks = 0;
		restart(7'h1D, 1'b1);
		chk(MGMT_ADDR, straps[2:0]);
		chk(DEFAULT_MODE, straps[5:3]);
		chk(RMII_MODE, straps[6]);
		chk(SMI_ADDR_HIT, 1'b1);
		SMI_ADDR = 3'h4;
		repeat (2) @(negedge CLK);
		chk(SMI_ADDR_HIT, 1'b0);
		straps = 7'h62;
		repeat (20) @(negedge CLK);
		chk(MGMT_ADDR, 3'h5);
		chk(RXER_RXD4, 1'b1);
		$display("test straps done");
		send(20'h2B747, 4);
		chk(sh[19:0], 20'h2B747);
		SYMBOL_MODE = 1'b1;
		send(20'h8BFC2, 4);
		chk(sh[19:0], 20'h8BFC2);
		{SYMBOL_MODE, CORE_CARRIER, CORE_COLLISION} = 3'h3;
		repeat (30) @(negedge CLK);
		chk({CRS, COL_CRSDV}, 2'h3);
		{CORE_CARRIER, CORE_COLLISION} = 2'h0;
		repeat (30) @(negedge CLK);
		chk({CRS, COL_CRSDV}, 2'h0);
		$display("test wide fast done");
		EEE_EN = 1'b0;
		restart(7'h1D, 1'b0);
		repeat (250) @(negedge CLK);
		chk(RXER_RXD4, 1'b0);
		{base, e, refused} = {cnt, 40'h0, 1'b0};
		for (int i = 0; i < 11; i++) begin
			push(5'(i), i == 10);
			e = {e[34:0], 5'(i)};
		end
		CORE_VALID = 1'b0;
		chk(refused, 1'b1);
		for (int i = 0; i < 3000 && cnt < base + 11; i++) @(negedge CLK);
		chk(sh, e);
		$display("test wide slow fill done");
		restart(7'h5D, 1'b1);
		chk(RMII_MODE, 1'b1);
		send(20'h2B747, 8);
		chk(sh[15:0], dib(20'h2B747, 0));
		restart(7'h5D, 1'b0);
		send(20'h195A7, 8);
		chk(sh[15:0], dib(20'h195A7, 2));
		{FULL_DUPLEX, TX_ACTIVE} = 2'h1;
		repeat (50) @(negedge CLK);
		send(20'h195A7, 0);
		repeat (400) @(negedge CLK);
		chk(cnt, base);
		{FULL_DUPLEX, TX_ACTIVE, straps, SYS_RESET} = {2'h2, 7'h47, 1'b1};
		@(negedge CLK);
		SYS_RESET = 1'b0;
		repeat (2) @(negedge CLK);
		for (int i = 0; i < 50 && !PIN_OE; i++) @(negedge CLK);
		chk({MGMT_ADDR, DEFAULT_MODE}, 6'h38);
		$display("test reduced done");
		end_of_test;
	end
endmodule // tb_top
